// file: hw/brpa_unit.sv
/*
 * Single-cycle execution slice: byte/bit reversal and signed parallel
 * lane arithmetic, one registered result per issued legal operation whose condition passes.
 * Assumes the decoder has already resolved the condition code into
 * cond_pass and presents operands read from the register file.
 */
// What this block does
// - word swap reverses the four bytes end to end.
// - halfword swap exchanges bytes inside each halfword, halfwords stay put.
// - signed halfword swap makes 32-bit signed result in opposite byte order.
// - swap bottom halfword bytes, then sign-extend into upper sixteen bits.
// - bit mirror puts operand bit i at result bit 31 minus i.
// - no operation here ever alters the N, Z, C, V flags.
// - dual half sum adds matching signed halfwords independently.
// - quad byte sum adds four signed bytes with no carry between lanes.
// - each lane sum lands in the lane position it came from.
// - halving sums add lanes then shift each sum right by one.
// - sum-diff exchange top is (a.top + b.bottom) halved.
// - sum-diff exchange bottom is (a.bottom - b.top) halved.
// - diff-sum exchange top is a.top-b.bottom, bottom a.bottom+b.top, halved.
// - omitted destination writes the result back to the first operand register.
// - every operation obeys the condition pass gate when qualified.
`timescale 1ns/1ps

module brpa_unit
    import brpa_pkg::*;
#(
    parameter int WORD_W = BRPA_WORD
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issue,
    input wire brpa_op_t op,
    input wire logic cond_pass,
    input wire logic dest_given,
    input wire logic [3:0] dest_reg,
    input wire logic [3:0] first_operand_reg,
    input wire logic [3:0] second_operand_reg,
    input wire logic [31:0] first_operand,
    input wire logic [31:0] second_operand,
    output logic result_valid,
    output logic [31:0] result,
    output logic [3:0] result_reg,
    output logic flags_write
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (WORD_W != BRPA_WORD) begin : g_bad_width
        $error("brpa_unit serves only a 32-bit word");
    end

    // ------------------------------------------------------------
    // reversal datapath
    // ------------------------------------------------------------
    logic [31:0] word_swap;
    logic [31:0] half_swap;
    logic [31:0] signed_low_swap;
    logic [31:0] bit_mirror;

    assign word_swap = {first_operand[7:0], first_operand[15:8],
                        first_operand[23:16], first_operand[31:24]};
    assign half_swap = {first_operand[23:16], first_operand[31:24],
                        first_operand[7:0], first_operand[15:8]};
    // swap low half, sign from the byte now on top
    assign signed_low_swap = {{BRPA_HALF{first_operand[7]}},
                              first_operand[7:0], first_operand[15:8]};

    for (genvar i = 0; i < BRPA_WORD; i++) begin : g_mirror
        assign bit_mirror[i] = first_operand[BRPA_WORD - 1 - i];
    end

    // ------------------------------------------------------------
    // lane arithmetic
    // ------------------------------------------------------------
    logic [31:0] byte_sum;
    logic [31:0] byte_hsum;
    logic [31:0] half_sum;
    logic [31:0] half_hsum;
    logic [16:0] xa_top;
    logic [16:0] xa_bot;
    logic [16:0] xs_top;
    logic [16:0] xs_bot;

    // byte lanes, no carry between them
    for (genvar b = 0; b < 4; b++) begin : g_byte
        logic [8:0] wide;
        assign wide = {first_operand[b*8+7], first_operand[b*8 +: 8]}
                    + {second_operand[b*8+7], second_operand[b*8 +: 8]};
        assign byte_sum[b*8 +: 8] = wide[7:0];
        assign byte_hsum[b*8 +: 8] = wide[8:1];
    end

    for (genvar h = 0; h < 2; h++) begin : g_half
        logic [16:0] wide;
        assign wide = {first_operand[h*16+15], first_operand[h*16 +: 16]}
                    + {second_operand[h*16+15], second_operand[h*16 +: 16]};
        assign half_sum[h*16 +: 16] = wide[15:0];
        assign half_hsum[h*16 +: 16] = wide[16:1];
    end

    // sum top / difference bottom, exchanged halves
    assign xa_top = {first_operand[31], first_operand[31:16]}
                  + {second_operand[15], second_operand[15:0]};
    assign xa_bot = {first_operand[15], first_operand[15:0]}
                  - {second_operand[31], second_operand[31:16]};
    // difference top / sum bottom, exchanged halves
    assign xs_top = {first_operand[31], first_operand[31:16]}
                  - {second_operand[15], second_operand[15:0]};
    assign xs_bot = {first_operand[15], first_operand[15:0]}
                  + {second_operand[31], second_operand[31:16]};

    // ------------------------------------------------------------
    // result select
    // ------------------------------------------------------------
    logic [31:0] next_result;

    // codes beyond the last operation are illegal, so a default stands
    always_comb begin
        unique case (op)
            BRPA_OP_WORD_BYTE_SWAP: next_result = word_swap;
            BRPA_OP_HALF_PAIR_SWAP: next_result = half_swap;
            BRPA_OP_SIGNED_LOW_SWAP: next_result = signed_low_swap;
            BRPA_OP_WORD_BIT_MIRROR: next_result = bit_mirror;
            BRPA_OP_DUAL_HALF_SUM: next_result = half_sum;
            BRPA_OP_QUAD_BYTE_SUM: next_result = byte_sum;
            BRPA_OP_DUAL_HALF_HSUM: next_result = half_hsum;
            BRPA_OP_QUAD_BYTE_HSUM: next_result = byte_hsum;
            BRPA_OP_HSUM_DIFF_XCHG: next_result = {xa_top[16:1], xa_bot[16:1]};
            BRPA_OP_HDIFF_SUM_XCHG: next_result = {xs_top[16:1], xs_bot[16:1]};
            default: next_result = BRPA_RESULT_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // writeback stage
    // ------------------------------------------------------------
    logic next_valid;
    logic [3:0] next_reg;

    // a failed condition retires with no write
    assign next_valid = issue && cond_pass && (op <= BRPA_OP_HDIFF_SUM_XCHG);
    // no destination given, first operand register takes it
    assign next_reg = dest_given ? dest_reg : first_operand_reg;

    // write strobe is one cycle; data held until the next valid issue
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_valid <= 1'b0;
            result <= BRPA_RESULT_RESET;
            result_reg <= BRPA_DEST_RESET;
        end else begin
            result_valid <= next_valid;
            if (next_valid) begin
                result <= next_result;
                result_reg <= next_reg;
            end
        end
    end

    // flags write strobe held low forever
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_write <= 1'b0;
        end else begin
            flags_write <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_issue_ok;
        issue && cond_pass && (op <= BRPA_OP_HDIFF_SUM_XCHG);
    endsequence

    a_flags_never_write: assert property (
        @(posedge clock) disable iff (!rst_n) ##1 !flags_write)
        else $error("flag write strobe raised");
    a_cond_gate_write: assert property (
        @(posedge clock) disable iff (!rst_n) issue && !cond_pass |=> !result_valid)
        else $error("write despite failed condition");
    a_issue_gives_write: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok |=> result_valid)
        else $error("passed operation not written");
    a_default_dest_first: assert property (
        @(posedge clock) disable iff (!rst_n)
        s_issue_ok and !dest_given |=> result_reg == $past(first_operand_reg))
        else $error("omitted destination not first operand");
    a_word_swap_value: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok and op == BRPA_OP_WORD_BYTE_SWAP
        |=> result[7:0] == $past(first_operand[31:24])
            && result[31:24] == $past(first_operand[7:0]))
        else $error("word byte swap wrong");
    a_signed_low_ext: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok and op == BRPA_OP_SIGNED_LOW_SWAP
        |=> result[31:16] == {16{$past(first_operand[7])}}
            && result[15:8] == $past(first_operand[7:0]))
        else $error("signed halfword swap wrong");
    a_mirror_ends: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok and op == BRPA_OP_WORD_BIT_MIRROR
        |=> result[31] == $past(first_operand[0]) && result[0] == $past(first_operand[31]))
        else $error("bit mirror wrong");
    a_byte_no_carry: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok and op == BRPA_OP_QUAD_BYTE_SUM
        |=> result[15:8] == 8'($past(first_operand[15:8]) + $past(second_operand[15:8])))
        else $error("byte lane sum wrong");
    a_xchg_top_half: assert property (
        @(posedge clock) disable iff (!rst_n) s_issue_ok and op == BRPA_OP_HSUM_DIFF_XCHG
        |=> result[31:16] == 16'(($past(signed'(first_operand[31:16]))
            + 17'($past(signed'(second_operand[15:0])))) >>> 1))
        else $error("exchange top half wrong");

endmodule

// file: include/brpa_pkg.sv
/*
 * Package for the byte-reverse and parallel-add execution slice:
 * operation codes, lane widths and register-number constants.
 * Assumes a 32-bit datapath and a 4-bit register number from the decoder.
 */
package brpa_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int BRPA_WORD = 32;
    localparam int BRPA_HALF = 16;
    localparam int BRPA_BYTE = 8;
    localparam int BRPA_REGW = 4;

    // ------------------------------------------------------------
    // reserved register numbers the decoder must never present
    // ------------------------------------------------------------
    localparam logic [3:0] BRPA_STACK_POINTER_REG = 4'hd;
    localparam logic [3:0] BRPA_PROGRAM_COUNTER_REG = 4'hf;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BRPA_OP_WORD_BYTE_SWAP = 4'h0,
        BRPA_OP_HALF_PAIR_SWAP = 4'h1,
        BRPA_OP_SIGNED_LOW_SWAP = 4'h2,
        BRPA_OP_WORD_BIT_MIRROR = 4'h3,
        BRPA_OP_DUAL_HALF_SUM = 4'h4,
        BRPA_OP_QUAD_BYTE_SUM = 4'h5,
        BRPA_OP_DUAL_HALF_HSUM = 4'h6,
        BRPA_OP_QUAD_BYTE_HSUM = 4'h7,
        BRPA_OP_HSUM_DIFF_XCHG = 4'h8,
        BRPA_OP_HDIFF_SUM_XCHG = 4'h9
    } brpa_op_t;

    // reset values of the result stage
    localparam logic [31:0] BRPA_RESULT_RESET = 32'h0000_0000;
    localparam logic [3:0] BRPA_DEST_RESET = 4'h0;

endpackage

// file: test/brpa_regfile_model.sv
/*
 * Register-file side model: keeps every written result by register number.
 * Assumes the unit's writeback ports and the single core clock.
 */
`timescale 1ns/1ps
module brpa_regfile_model (
    input wire logic clock,
    input wire logic result_valid,
    input wire logic [3:0] result_reg,
    input wire logic [31:0] result
);
    // writeback capture; no reset since entries are read only after a write
    logic [31:0] regs [16];
    always_ff @(posedge clock) begin
        if (result_valid) begin
            regs[result_reg] <= result;
        end
    end
endmodule

// file: test/test_byte_reverse_parallel_add_unit.sv
/*
 * Self-checking bench for the reversal and parallel lane slice.
 * Assumes brpa_pkg, brpa_unit and the register-file model; inputs change on falling edges.
 */
`timescale 1ns/1ps
module test_byte_reverse_parallel_add_unit;
    import brpa_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clock = 0, rst_n = 0, issue = 0, cond_pass = 0, dest_given = 0;
    brpa_op_t op = BRPA_OP_WORD_BYTE_SWAP;
    logic [3:0] dest_reg = 4'h0, first_operand_reg = 4'h0, second_operand_reg = 4'h0;
    logic [31:0] first_operand = 32'h0, second_operand = 32'h0, result, last = 32'h0;
    logic [3:0] result_reg, last_reg = 4'h0;
    logic result_valid, flags_write;
    int failures = 0, compares = 0, cycles = 0;
    logic [31:0] vec_a [3] = '{32'h12a4_8c7f, 32'h7fff_80ff, 32'h8000_0101};
    logic [31:0] vec_b [3] = '{32'h8081_7f01, 32'h7f01_8081, 32'hffff_8000};
    brpa_unit i_dut (.clock(clock), .rst_n(rst_n), .issue(issue), .op(op),
        .cond_pass(cond_pass), .dest_given(dest_given), .dest_reg(dest_reg),
        .first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg),
        .first_operand(first_operand), .second_operand(second_operand),
        .result_valid(result_valid), .result(result), .result_reg(result_reg),
        .flags_write(flags_write));
    brpa_regfile_model i_rf (.clock(clock), .result_valid(result_valid),
        .result_reg(result_reg), .result(result));
    // clock and a hang limit well above the fifty or so cycles needed
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // reference arithmetic, one extra sign bit before halving
    // ------------------------------------------------------------
    function automatic logic [15:0] h16(input logic [15:0] x, y, input logic sub);
        logic [16:0] s;
        s = sub ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
        return s[16:1];
    endfunction
    function automatic logic [7:0] h8(input logic [7:0] x, y);
        logic [8:0] s;
        s = {x[7], x} + {y[7], y};
        return s[8:1];
    endfunction
    function automatic logic [31:0] ref_calc(input logic [3:0] o, input logic [31:0] a, b);
        logic [31:0] r;
        r = 32'h0;
        case (o)
            4'h0: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
            4'h1: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
            4'h2: r = {{16{a[7]}}, a[7:0], a[15:8]};
            4'h3: for (int i = 0; i < 32; i++) r[31 - i] = a[i];
            4'h4: r = {16'(a[31:16] + b[31:16]), 16'(a[15:0] + b[15:0])};
            4'h5: for (int k = 0; k < 4; k++) r[8*k +: 8] = a[8*k +: 8] + b[8*k +: 8];
            4'h6: r = {h16(a[31:16], b[31:16], 1'b0), h16(a[15:0], b[15:0], 1'b0)};
            4'h7: for (int k = 0; k < 4; k++) r[8*k +: 8] = h8(a[8*k +: 8], b[8*k +: 8]);
            4'h8: r = {h16(a[31:16], b[15:0], 1'b0), h16(a[15:0], b[31:16], 1'b1)};
            4'h9: r = {h16(a[31:16], b[15:0], 1'b1), h16(a[15:0], b[31:16], 1'b0)};
            default: r = 32'h0;
        endcase
        return r;
    endfunction
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // issue stays high between calls so back-to-back ops need no gap
    task automatic run_op(input logic [3:0] o, input logic [31:0] a, b, input logic pass,
        input logic dg, input logic [3:0] d, input logic [3:0] fr);
        logic taken;
        taken = pass && (o <= 4'h9);
        op = brpa_op_t'(o);
        first_operand = a;
        second_operand = b;
        cond_pass = pass;
        dest_given = dg;
        dest_reg = d;
        first_operand_reg = fr;
        second_operand_reg = 4'h2;
        issue = 1'b1;
        @(negedge clock);
        if (taken) begin
            last = ref_calc(o, a, b);
            last_reg = dg ? d : fr;
        end
        chk("result_valid", {31'h0, taken}, {31'h0, result_valid});
        chk("result", last, result);
        chk("result_reg", {28'h0, last_reg}, {28'h0, result_reg});
        chk("flags_write", 32'h0, {31'h0, flags_write});
    endtask
    task automatic end_test(input string n);
        issue = 1'b0;
        @(negedge clock);
        chk("idle valid", 32'h0, {31'h0, result_valid});
        $display("%s finished", n);
    endtask
    task automatic run_range(input logic [3:0] lo, hi);
        for (logic [4:0] o = 5'(lo); o <= 5'(hi); o++) begin
            for (int v = 0; v < 3; v++) run_op(o[3:0], vec_a[v], vec_b[v], 1'b1, 1'b1, 4'h7, 4'h1);
        end
    endtask
    task automatic t_reversal();
        run_range(4'h0, 4'h3);
        end_test("reversal");
    endtask
    task automatic t_lane_sums();
        run_range(4'h4, 4'h5);
        end_test("lane sums");
    endtask
    task automatic t_halving();
        run_range(4'h6, 4'h9);
        end_test("halving");
    endtask
    task automatic t_gating();
        run_op(4'h4, vec_a[1], vec_b[1], 1'b0, 1'b1, 4'h5, 4'h1);
        run_op(4'hc, vec_a[2], vec_b[2], 1'b1, 1'b1, 4'h6, 4'h1);
        run_op(4'h8, vec_a[1], vec_b[2], 1'b1, 1'b1, 4'h6, 4'h1);
        end_test("gating");
    endtask
    task automatic t_dest_omit();
        run_op(4'h5, vec_a[0], vec_b[0], 1'b1, 1'b0, 4'h9, 4'h3);
        end_test("dest omit");
        chk("regfile", ref_calc(4'h5, vec_a[0], vec_b[0]), i_rf.regs[3]);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clock);
        chk("reset result", BRPA_RESULT_RESET, result);
        chk("reset valid", 32'h0, {31'h0, result_valid});
        rst_n = 1'b1;
        @(negedge clock);
        t_reversal();
        t_lane_sums();
        t_halving();
        t_gating();
        t_dest_omit();
        wrap_up();
    end
endmodule
